// ### cedc_display_ctrl.sv
/*
 * Extended display control: indexed registers, start address double
 * buffering, interlace and blanking gating, address wrap and the pixel
 * capture path of the palette DAC mode logic.
 * Assumes the base CRTC and sequencer run on sys_clk and feed their
 * strobes here; pixel clock and pixel data arrive asynchronously on pins.
 */
`timescale 1ns/1ps
module cedc_display_ctrl (
   input wire logic sys_clk,
   input wire logic rst,
   input cedc_pkg::cedc_io_req_t io_req,
   output logic [7:0] io_rdata,
   input wire logic [15:0] base_start_addr,
   input wire logic start_low_write,
   input wire logic vsync,
   input wire logic vint_event,
   input wire logic odd_field,
   input wire logic graphics_mode,
   output logic interlace_sync_en,
   output logic interlace_data_en,
   output logic vint_req,
   output logic [18:0] display_start_addr,
   output logic [1:0] hblank_end_ext,
   output logic [1:0] vblank_end_ext,
   output logic font_fast_page,
   input wire logic crtc_blank,
   input wire logic display_enable,
   output logic dac_blank,
   output logic overlay_window_n_o,
   output logic overlay_window_n_oe,
   input wire logic [7:0] row_offset_register,
   output logic [8:0] row_offset,
   input wire logic chain_four_bit,
   input wire logic double_word_mode_bit,
   input wire logic [16:12] host_address,
   input wire logic [6:0] host_offset,
   input wire logic [15:0] crtc_addr,
   input wire logic [19:0] mem_addr_in,
   output logic [18:12] extended_host_address,
   output logic [19:0] mem_addr,
   input wire logic char_load,
   input wire logic char_advance,
   output logic [18:0] character_counter_address,
   input wire logic external_video_enable_n,
   output logic overlay_timing_n,
   output logic ext_dac_select,
   output cedc_pkg::cedc_dac_mode_t dac_mode,
   input wire logic pixel_input_clock,
   input wire logic [7:0] pixel_data,
   output logic capture_ready,
   output logic capture_overrun,
   output cedc_pkg::cedc_pix_t pix_out,
   output logic pix_valid,
   input wire logic pix_ready
);
   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] misc;
      logic [7:0] ext;
      logic [7:0] ovl;
      logic [7:0] hdac;
      logic [7:0] rdata;
      logic pend;
      logic [18:0] shadow;
      logic [18:0] start;
      logic vs_prev;
      logic [18:0] cc;
      logic pclk_s1;
      logic pclk_s2;
      logic pclk_prev;
      logic [7:0] pd_s1;
      logic [7:0] pd_s2;
      logic evid_s1;
      logic evid_s2;
      logic [7:0] lo_byte;
      logic phase;
      logic overrun;
      cedc_pkg::cedc_pix_t b0;
      cedc_pkg::cedc_pix_t b1;
      logic [1:0] cnt;
   } cedc_state_t;

   cedc_state_t st_q;
   cedc_state_t st_d;

   function automatic cedc_pkg::cedc_dac_mode_t cedc_decode(
      input logic [7:0] h);
      cedc_pkg::cedc_dac_mode_t m;
      m = cedc_pkg::CEDC_DAC_RSVD;
      if (!h[cedc_pkg::HDAC_EN555]) begin
         m = cedc_pkg::CEDC_DAC_VGA;
      end else if (!h[cedc_pkg::HDAC_ALLEXT]) begin
         m = cedc_pkg::CEDC_DAC_555;
      end else begin
         unique casez (h[3:0])
            4'h0: m = cedc_pkg::CEDC_DAC_555;
            4'h1: m = cedc_pkg::CEDC_DAC_565;
            4'h5: m = cedc_pkg::CEDC_DAC_888;
            4'b011?: m = cedc_pkg::CEDC_DAC_PWRDN;
            4'h8: m = cedc_pkg::CEDC_DAC_GRAY8;
            4'h9: m = cedc_pkg::CEDC_DAC_RGB332;
            default: m = cedc_pkg::CEDC_DAC_RSVD;
         endcase
      end
      return m;
   endfunction

   logic is_idx_port;
   logic is_dat_port;
   logic is_hdac_port;
   logic vs_rise;
   logic [18:0] new_start;
   logic [18:0] cc_mask;
   logic pclk_rise;
   logic pclk_fall;
   logic is16;
   logic cap_valid;
   logic [15:0] cap_word;
   logic [6:0] xma_sum;
   logic blank_ext_on;
   logic switch_true;
   logic [7:0] dat_rd;
   logic push;
   logic pop;

   assign is_idx_port = (io_req.addr == cedc_pkg::PORT_IDX_COL)
                      || (io_req.addr == cedc_pkg::PORT_IDX_MONO);
   assign is_dat_port = (io_req.addr == cedc_pkg::PORT_DAT_COL)
                      || (io_req.addr == cedc_pkg::PORT_DAT_MONO);
   assign is_hdac_port = (io_req.addr == cedc_pkg::PORT_HIDDEN_DAC);
   assign vs_rise = vsync && !st_q.vs_prev;
   assign pclk_rise = st_q.pclk_s2 && !st_q.pclk_prev;
   assign pclk_fall = !st_q.pclk_s2 && st_q.pclk_prev;

   assign new_start = {st_q.ext[cedc_pkg::EXT_SA18]
                       && cedc_pkg::LARGE_MEMBER,
                       st_q.ext[cedc_pkg::EXT_SA17],
                       st_q.ext[cedc_pkg::EXT_SA16], base_start_addr};

   assign cc_mask = !st_q.ext[cedc_pkg::EXT_WRAP] ? cedc_pkg::CC_MASK16
                  : (cedc_pkg::LARGE_MEMBER ? cedc_pkg::CC_MASK19
                                            : cedc_pkg::CC_MASK18);

   assign dac_mode = cedc_decode(st_q.hdac);
   assign is16 = (dac_mode == cedc_pkg::CEDC_DAC_555)
              || (dac_mode == cedc_pkg::CEDC_DAC_565);

   always_comb begin
      cap_valid = 1'b0;
      cap_word = {8'h00, st_q.pd_s2};
      if (is16) begin
         if (!st_q.hdac[cedc_pkg::HDAC_CLKMODE]) begin
            cap_valid = pclk_fall;
            cap_word = {st_q.pd_s2, st_q.lo_byte};
         end else begin
            cap_valid = pclk_rise && st_q.phase;
            cap_word = {st_q.pd_s2, st_q.lo_byte};
         end
      end else begin
         cap_valid = pclk_rise;
      end
   end

   assign capture_ready = (st_q.cnt != cedc_pkg::BUF_DEPTH);
   assign push = cap_valid && capture_ready;
   assign pop = pix_ready && (st_q.cnt != 2'h0);
   assign pix_valid = (st_q.cnt != 2'h0);
   assign pix_out = st_q.b0;
   assign capture_overrun = st_q.overrun;

   always_comb begin
      unique case (st_q.idx)
         cedc_pkg::IDX_MISC: dat_rd = st_q.misc;
         cedc_pkg::IDX_EXT: dat_rd = st_q.ext;
         cedc_pkg::IDX_OVL: dat_rd = st_q.ovl & cedc_pkg::OVL_WR_MASK;
         cedc_pkg::IDX_PART: dat_rd = cedc_pkg::PART_STATUS_VALUE;
         cedc_pkg::IDX_ID: dat_rd = {cedc_pkg::CHIP_ID_CODE, 2'h0};
         default: dat_rd = 8'h00;
      endcase
   end

   always_comb begin
      st_d = st_q;
      st_d.vs_prev = vsync;
      st_d.pclk_s1 = pixel_input_clock;
      st_d.pclk_s2 = st_q.pclk_s1;
      st_d.pclk_prev = st_q.pclk_s2;
      st_d.pd_s1 = pixel_data;
      st_d.pd_s2 = st_q.pd_s1;
      st_d.evid_s1 = external_video_enable_n;
      st_d.evid_s2 = st_q.evid_s1;
      if (io_req.wr) begin
         if (is_idx_port) begin
            st_d.idx = io_req.wdata;
         end else if (is_hdac_port) begin
            st_d.hdac = io_req.wdata;
         end else if (is_dat_port) begin
            unique case (st_q.idx)
               cedc_pkg::IDX_MISC: st_d.misc = io_req.wdata;
               cedc_pkg::IDX_EXT: st_d.ext = io_req.wdata;
               cedc_pkg::IDX_OVL:
                  st_d.ovl = io_req.wdata & cedc_pkg::OVL_WR_MASK;
               default: st_d.idx = st_q.idx;
            endcase
         end
      end
      if (io_req.rd) begin
         if (is_idx_port) begin
            st_d.rdata = st_q.idx;
         end else if (is_dat_port) begin
            st_d.rdata = dat_rd;
         end else if (is_hdac_port) begin
            st_d.rdata = st_q.hdac;
         end else begin
            st_d.rdata = 8'h00;
         end
      end
      if (st_q.misc[cedc_pkg::MISC_DBUF]) begin
         if (vs_rise && st_q.pend) begin
            st_d.start = st_q.shadow;
            st_d.pend = 1'b0;
         end
         // A write landing on the vsync edge re-arms for the next frame.
         if (start_low_write) begin
            st_d.shadow = new_start;
            st_d.pend = 1'b1;
         end
      end else begin
         st_d.start = new_start;
         st_d.pend = 1'b0;
      end
      if (char_load) begin
         st_d.cc = st_q.start & cc_mask;
      end else if (char_advance) begin
         st_d.cc = (st_q.cc + 19'h00001) & cc_mask;
      end else begin
         st_d.cc = st_q.cc & cc_mask;
      end
      // first byte of a 16-bit pixel
      if (is16 && pclk_rise) begin
         st_d.lo_byte = st_q.pd_s2;
         st_d.phase = st_q.hdac[cedc_pkg::HDAC_CLKMODE] ? !st_q.phase
                                                        : 1'b0;
      end else if (!is16) begin
         st_d.phase = 1'b0;
      end
      // The pixel pin cannot be stalled, so a full buffer flags a loss.
      st_d.overrun = st_q.overrun || (cap_valid && !capture_ready);
      if (pop) begin
         st_d.b0 = st_q.b1;
         st_d.cnt = st_q.cnt - 2'h1;
      end
      if (push) begin
         if ((dac_mode == cedc_pkg::CEDC_DAC_555)
             && st_q.hdac[cedc_pkg::HDAC_32K] && cap_word[15]) begin
            if ((pop ? st_q.cnt - 2'h1 : st_q.cnt) == 2'h0) begin
               st_d.b0 = '{pal_sel: 1'b1, data: {8'h00, cap_word[7:0]}};
            end else begin
               st_d.b1 = '{pal_sel: 1'b1, data: {8'h00, cap_word[7:0]}};
            end
         end else if ((pop ? st_q.cnt - 2'h1 : st_q.cnt) == 2'h0) begin
            st_d.b0 = '{pal_sel: 1'b0, data: cap_word};
         end else begin
            st_d.b1 = '{pal_sel: 1'b0, data: cap_word};
         end
         st_d.cnt = (pop ? st_q.cnt : st_q.cnt + 2'h1);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
         st_q.misc <= cedc_pkg::RST_MISC;
         st_q.ext <= cedc_pkg::RST_EXT;
         st_q.ovl <= cedc_pkg::RST_OVL;
         st_q.hdac <= cedc_pkg::RST_HDAC;
      end else begin
         st_q <= st_d;
      end
   end

   assign io_rdata = st_q.rdata;
   assign display_start_addr = st_q.start;
   assign character_counter_address = st_q.cc;

   assign interlace_sync_en = st_q.misc[cedc_pkg::MISC_INTERLACE];
   assign interlace_data_en = st_q.misc[cedc_pkg::MISC_INTERLACE]
                           && graphics_mode;
   assign vint_req = vint_event
                  && (!st_q.misc[cedc_pkg::MISC_INTERLACE] || odd_field);
   assign blank_ext_on = st_q.ext[cedc_pkg::EXT_BEXT]
                      || st_q.ext[cedc_pkg::EXT_BLANK];
   assign hblank_end_ext = blank_ext_on ? st_q.misc[5:4] : 2'h0;
   assign vblank_end_ext = blank_ext_on ? st_q.misc[7:6] : 2'h0;
   assign font_fast_page = st_q.ext[cedc_pkg::EXT_FPAGE];
   assign dac_blank = st_q.ext[cedc_pkg::EXT_BLANK] ? !display_enable
                                                    : crtc_blank;
   assign overlay_window_n_oe = st_q.ext[cedc_pkg::EXT_BLANK];
   assign overlay_window_n_o = !crtc_blank;
   assign row_offset = {st_q.ext[cedc_pkg::EXT_OFS8], row_offset_register};

   assign xma_sum = {2'h0, host_address} + host_offset;
   assign extended_host_address = xma_sum;

   always_comb begin
      // wrap at 256K or full size
      mem_addr = mem_addr_in & (st_q.ext[cedc_pkg::EXT_WRAP]
                 ? cedc_pkg::MEM_WRAP_FULL : cedc_pkg::MEM_WRAP_VGA);
      if (st_q.ext[cedc_pkg::EXT_WRAP] && chain_four_bit) begin
         mem_addr[1:0] = {xma_sum[5], xma_sum[4]};
      end else if (st_q.ext[cedc_pkg::EXT_WRAP] && double_word_mode_bit) begin
         mem_addr[1:0] = {crtc_addr[15], crtc_addr[14]};
      end
   end

   assign overlay_timing_n = (st_q.misc[3:2] == 2'h1
                              || st_q.misc[3:2] == 2'h2)
      ? (st_q.ovl[cedc_pkg::OVL_SRC] ? !overlay_window_n_oe
                                       || overlay_window_n_o
                                     : st_q.evid_s2)
      : 1'b1;
   assign switch_true = !overlay_timing_n;
   assign ext_dac_select = (st_q.ovl[2:1] == 2'h0) ? switch_true
                         : (st_q.ovl[2:1] == 2'h1) ? !switch_true : 1'b0;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_vs_apply;
      st_q.misc[cedc_pkg::MISC_DBUF] && st_q.pend && vs_rise
         && !start_low_write;
   endsequence

   db_start_load_a: assert property (
      s_vs_apply |=> (display_start_addr == $past(st_q.shadow)) && !st_q.pend)
      else $error("start address not loaded at vsync");
   db_start_hold_a: assert property (
      st_q.misc[cedc_pkg::MISC_DBUF] && !vs_rise
         && $stable(st_q.misc) |=> $stable(display_start_addr))
      else $error("start address moved outside vsync");
   interlace_out_a: assert property (
      interlace_data_en |-> interlace_sync_en && graphics_mode)
      else $error("interlaced data without graphics sync");
   vint_odd_a: assert property (
      vint_event && interlace_sync_en && !odd_field |-> !vint_req)
      else $error("vertical request on even field");
   blank_ext_a: assert property (
      !st_q.ext[7] && !st_q.ext[5] |-> hblank_end_ext == 2'h0
         && vblank_end_ext == 2'h0)
      else $error("blank extensions not gated");
   dac_blank_a: assert property (
      st_q.ext[5] |-> dac_blank == !display_enable)
      else $error("DAC blank not from display enable");
   ovl_pin_a: assert property (
      overlay_window_n_oe |-> overlay_window_n_o != crtc_blank)
      else $error("overlay window pin not tracking blank");
   row_offset_a: assert property (
      row_offset[8] == st_q.ext[4])
      else $error("row offset bit 8 wrong");
   cc_width_a: assert property (
      !st_q.ext[1] && $stable(st_q.ext) |=> character_counter_address[18:16]
         == 3'h0)
      else $error("character counter exceeds 16 bits");
   dac_mode_a: assert property (
      st_q.hdac[7] && !st_q.hdac[6] |-> dac_mode == cedc_pkg::CEDC_DAC_555)
      else $error("5-5-5 mode not selected");
   dual_edge_a: assert property (
      is16 && !st_q.hdac[5] && pclk_rise ##1 !pclk_fall[*1] ##0 !pclk_rise
         |-> !cap_valid)
      else $error("capture without falling edge");
   rise_only_a: assert property (
      !is16 && pclk_fall |-> !cap_valid)
      else $error("capture on falling edge outside 16-bit");
endmodule

// ### cedc_pkg.sv
/*
 * Constants and carrier types for the extended display control block.
 * Assumes one 10 MHz system clock and an 8-bit indexed I/O register port.
 */
package cedc_pkg;
   // I/O port addresses.
   localparam logic [15:0] PORT_IDX_MONO = 16'h03B4;
   localparam logic [15:0] PORT_DAT_MONO = 16'h03B5;
   localparam logic [15:0] PORT_IDX_COL = 16'h03D4;
   localparam logic [15:0] PORT_DAT_COL = 16'h03D5;
   localparam logic [15:0] PORT_HIDDEN_DAC = 16'h03C6;
   // Register indexes behind the data port.
   localparam logic [7:0] IDX_MISC = 8'h1A;
   localparam logic [7:0] IDX_EXT = 8'h1B;
   localparam logic [7:0] IDX_OVL = 8'h1D;
   localparam logic [7:0] IDX_PART = 8'h25;
   localparam logic [7:0] IDX_ID = 8'h27;
   // Values after reset.
   localparam logic [7:0] RST_MISC = 8'h00;
   localparam logic [7:0] RST_EXT = 8'h00;
   localparam logic [7:0] RST_OVL = 8'h00;
   localparam logic [7:0] RST_HDAC = 8'h00;
   // Writable bits of the overlay mode register.
   localparam logic [7:0] OVL_WR_MASK = 8'h46;
   // Field positions, misc_display_control.
   localparam int MISC_INTERLACE = 0;
   localparam int MISC_DBUF = 1;
   localparam int MISC_OVL_LO = 2;
   localparam int MISC_HBE_LO = 4;
   localparam int MISC_VBE_LO = 6;
   // Field positions, extended_display_controls.
   localparam int EXT_SA16 = 0;
   localparam int EXT_WRAP = 1;
   localparam int EXT_SA17 = 2;
   localparam int EXT_SA18 = 3;
   localparam int EXT_OFS8 = 4;
   localparam int EXT_BLANK = 5;
   localparam int EXT_FPAGE = 6;
   localparam int EXT_BEXT = 7;
   // Field positions, overlay_mode_control and hidden_dac_mode.
   localparam int OVL_SW_LO = 1;
   localparam int OVL_SRC = 6;
   localparam int HDAC_EN555 = 7;
   localparam int HDAC_ALLEXT = 6;
   localparam int HDAC_CLKMODE = 5;
   localparam int HDAC_32K = 4;
   // Address wrap and counter widths.
   localparam logic [18:0] CC_MASK16 = 19'h0FFFF;
   localparam logic [18:0] CC_MASK18 = 19'h3FFFF;
   localparam logic [18:0] CC_MASK19 = 19'h7FFFF;
   localparam logic [19:0] MEM_WRAP_VGA = 20'h3FFFF;
   localparam logic [19:0] MEM_WRAP_FULL = 20'hFFFFF;
   // Family member options.
   localparam logic LARGE_MEMBER = 1'b1;
   // Arbitrary identification and status values.
   localparam logic [5:0] CHIP_ID_CODE = 6'h15;
   localparam logic [7:0] PART_STATUS_VALUE = 8'h00;
   // Buffer depth.
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   typedef enum logic [2:0] {
      CEDC_DAC_VGA, CEDC_DAC_555, CEDC_DAC_565, CEDC_DAC_888,
      CEDC_DAC_PWRDN, CEDC_DAC_GRAY8, CEDC_DAC_RGB332, CEDC_DAC_RSVD
   } cedc_dac_mode_t;

   typedef struct packed {
      logic pal_sel;
      logic [15:0] data;
   } cedc_pix_t;

   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } cedc_io_req_t;
endpackage

// ### cedc_pix_src.sv
/* Pixel source model that stands at the far side of the capture pins.
   Assumes the bench calls its task from one process, one byte at a time. */
`timescale 1ns/1ps
module cedc_pix_src (
   input wire logic sys_clk,
   output logic pixel_input_clock,
   output logic [7:0] pixel_data
);
   initial begin
      pixel_input_clock = 1'b0;
      pixel_data = 8'h00;
   end
   task automatic edge_byte(input logic [7:0] b, input logic lvl);
      @(posedge sys_clk) pixel_data <= b;
      repeat (2) @(posedge sys_clk);
      pixel_input_clock <= lvl;
      // Held past the sync delay, then spoiled so stale data cannot pass.
      repeat (6) @(posedge sys_clk);
      pixel_data <= ~b;
   endtask
endmodule

// ### crtc_extended_display_control_tb.sv
/* Self-checking bench for the extended display control block.
   Assumes the single 10 MHz clock and the pixel source model. */
`timescale 1ns/1ps
module crtc_extended_display_control_tb;
   typedef struct packed {
      logic hid;
      logic [7:0] idx;
      logic [7:0] wdata;
      logic [7:0] exp;
      cedc_pkg::cedc_dac_mode_t mode;
   } cedc_row_t;
   localparam cedc_row_t ROWS [16] = '{
      '{1'b0, 8'h1A, 8'h55, 8'h55, cedc_pkg::CEDC_DAC_VGA},
      '{1'b0, 8'h1B, 8'hFF, 8'hFF, cedc_pkg::CEDC_DAC_VGA},
      '{1'b0, 8'h1D, 8'hFF, 8'h46, cedc_pkg::CEDC_DAC_VGA},
      '{1'b0, 8'h25, 8'hFF, cedc_pkg::PART_STATUS_VALUE,
        cedc_pkg::CEDC_DAC_VGA},
      '{1'b0, 8'h27, 8'hFF, {cedc_pkg::CHIP_ID_CODE, 2'h0},
        cedc_pkg::CEDC_DAC_VGA},
      '{1'b0, 8'h30, 8'hFF, 8'h00, cedc_pkg::CEDC_DAC_VGA},
      '{1'b1, 8'h00, 8'h80, 8'h80, cedc_pkg::CEDC_DAC_555},
      '{1'b1, 8'h00, 8'h8F, 8'h8F, cedc_pkg::CEDC_DAC_555},
      '{1'b1, 8'h00, 8'hC0, 8'hC0, cedc_pkg::CEDC_DAC_555},
      '{1'b1, 8'h00, 8'hC1, 8'hC1, cedc_pkg::CEDC_DAC_565},
      '{1'b1, 8'h00, 8'hC5, 8'hC5, cedc_pkg::CEDC_DAC_888},
      '{1'b1, 8'h00, 8'hC6, 8'hC6, cedc_pkg::CEDC_DAC_PWRDN},
      '{1'b1, 8'h00, 8'hC8, 8'hC8, cedc_pkg::CEDC_DAC_GRAY8},
      '{1'b1, 8'h00, 8'hC9, 8'hC9, cedc_pkg::CEDC_DAC_RGB332},
      '{1'b1, 8'h00, 8'hC2, 8'hC2, cedc_pkg::CEDC_DAC_RSVD},
      '{1'b1, 8'h00, 8'h00, 8'h00, cedc_pkg::CEDC_DAC_VGA}};
   logic sys_clk, rst, start_low_write, vsync, vint_event, odd_field;
   cedc_pkg::cedc_io_req_t io_req;
   logic [7:0] io_rdata, rv, row_offset_register, pixel_data;
   logic [15:0] base_start_addr, crtc_addr;
   logic graphics_mode, interlace_sync_en, interlace_data_en, vint_req;
   logic [18:0] display_start_addr, character_counter_address;
   logic [1:0] hblank_end_ext, vblank_end_ext;
   logic font_fast_page, crtc_blank, display_enable, dac_blank;
   logic overlay_window_n_o, overlay_window_n_oe, char_load, char_advance;
   logic [8:0] row_offset;
   logic chain_four_bit, double_word_mode_bit;
   logic [16:12] host_address;
   logic [6:0] host_offset;
   logic [19:0] mem_addr_in, mem_addr;
   logic [18:12] extended_host_address;
   logic external_video_enable_n, overlay_timing_n, ext_dac_select;
   cedc_pkg::cedc_dac_mode_t dac_mode;
   logic pixel_input_clock, capture_ready, capture_overrun;
   logic pix_valid, pix_ready;
   cedc_pkg::cedc_pix_t pix_out;
   int n_errors = 0;
   int checked = 0;

   cedc_display_ctrl u_dut (.*);
   cedc_pix_src u_src (.*);

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic end_sim;
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // A request holds for one edge, then an idle edge separates the next.
   task automatic bus(input logic [15:0] a, input logic w,
                      input logic [7:0] d);
      @(posedge sys_clk);
      io_req <= '{addr: a, wr: w, rd: !w, wdata: d};
      @(posedge sys_clk);
      io_req.wr <= 1'b0;
      io_req.rd <= 1'b0;
      #1 rv = io_rdata;
   endtask

   task automatic creg(input logic [7:0] i, input logic [7:0] d);
      bus(cedc_pkg::PORT_IDX_COL, 1'b1, i);
      bus(cedc_pkg::PORT_DAT_COL, 1'b1, d);
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic pop;
      @(posedge sys_clk) pix_ready <= 1'b1;
      @(posedge sys_clk) pix_ready <= 1'b0;
      #1;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      end_sim();
   end

   initial begin
      rst = 1'b1;
      io_req = '0;
      {start_low_write, vsync, vint_event, odd_field, graphics_mode} = '0;
      {char_load, char_advance, chain_four_bit, double_word_mode_bit} = '0;
      {crtc_blank, display_enable, pix_ready} = 3'h6;
      external_video_enable_n = 1'b1;
      base_start_addr = 16'h1234;
      crtc_addr = 16'h0000;
      row_offset_register = 8'h5A;
      host_address = 5'h1F;
      host_offset = 7'h01;
      mem_addr_in = 20'hFFFFF;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (ROWS[k]) begin
         if (ROWS[k].hid) begin
            bus(cedc_pkg::PORT_HIDDEN_DAC, 1'b1, ROWS[k].wdata);
            bus(cedc_pkg::PORT_HIDDEN_DAC, 1'b0, 8'h00);
         end else begin
            creg(ROWS[k].idx, ROWS[k].wdata);
            bus(cedc_pkg::PORT_DAT_COL, 1'b0, 8'h00);
         end
         chk(rv, ROWS[k].exp);
         chk(dac_mode, ROWS[k].mode);
      end
      $display("test registers done");
      creg(8'h1A, 8'hF0);
      creg(8'h1B, 8'h00);
      chk({hblank_end_ext, vblank_end_ext, dac_blank}, 5'h01);
      chk({overlay_window_n_oe, font_fast_page}, 2'h0);
      creg(8'h1B, 8'h80);
      chk({hblank_end_ext, vblank_end_ext}, 4'hF);
      creg(8'h1B, 8'h75);
      step(1);
      chk({hblank_end_ext, vblank_end_ext, dac_blank}, 5'h1E);
      chk({overlay_window_n_oe, overlay_window_n_o}, 2'h2);
      chk({font_fast_page, row_offset}, 10'h35A);
      chk(display_start_addr, 19'h31234);
      creg(8'h1B, 8'h08);
      step(1);
      chk(display_start_addr, 19'h41234);
      $display("test display controls done");
      creg(8'h1A, 8'h02);
      @(posedge sys_clk) base_start_addr <= 16'hBEEF;
      start_low_write <= 1'b1;
      @(posedge sys_clk) start_low_write <= 1'b0;
      step(3);
      chk(display_start_addr, 19'h41234);
      @(posedge sys_clk) vsync <= 1'b1;
      @(posedge sys_clk) vsync <= 1'b0;
      base_start_addr <= 16'hFFFF;
      step(2);
      chk(display_start_addr, 19'h4BEEF);
      @(posedge sys_clk) vsync <= 1'b1;
      step(3);
      chk(display_start_addr, 19'h4BEEF);
      creg(8'h1A, 8'h01);
      chk({interlace_sync_en, interlace_data_en}, 2'h2);
      @(posedge sys_clk) graphics_mode <= 1'b1;
      vint_event <= 1'b1;
      step(1);
      chk({interlace_sync_en, interlace_data_en, vint_req}, 3'h6);
      @(posedge sys_clk) odd_field <= 1'b1;
      step(1);
      chk(vint_req, 1'b1);
      @(posedge sys_clk) vint_event <= 1'b0;
      $display("test start and interlace done");
      creg(8'h1B, 8'h00);
      step(1);
      chk(mem_addr, 20'h3FFFF);
      for (int w = 0; w < 2; w++) begin
         creg(8'h1B, {6'h00, w[0], 1'b0});
         step(1);
         @(posedge sys_clk) char_load <= 1'b1;
         @(posedge sys_clk) char_load <= 1'b0;
         char_advance <= 1'b1;
         @(posedge sys_clk) char_advance <= 1'b0;
         step(1);
         chk(character_counter_address, w ? 19'h10000 : 19'h0);
      end
      chk(mem_addr, 20'hFFFFF);
      chk(extended_host_address, 7'h20);
      @(posedge sys_clk) chain_four_bit <= 1'b1;
      step(1);
      chk(mem_addr, 20'hFFFFE);
      @(posedge sys_clk) chain_four_bit <= 1'b0;
      double_word_mode_bit <= 1'b1;
      crtc_addr <= 16'h4000;
      step(1);
      chk(mem_addr, 20'hFFFFD);
      $display("test wrap done");
      creg(8'h1A, 8'h04);
      @(posedge sys_clk) external_video_enable_n <= 1'b0;
      step(4);
      creg(8'h1D, 8'h00);
      chk({overlay_timing_n, ext_dac_select}, 2'h1);
      creg(8'h1D, 8'h02);
      chk(ext_dac_select, 1'b0);
      creg(8'h1D, 8'h04);
      chk(ext_dac_select, 1'b0);
      @(posedge sys_clk) external_video_enable_n <= 1'b1;
      creg(8'h1D, 8'h02);
      step(4);
      chk({overlay_timing_n, ext_dac_select}, 2'h3);
      creg(8'h1B, 8'h20);
      creg(8'h1D, 8'h40);
      step(1);
      chk(overlay_timing_n, 1'b0);
      $display("test overlay done");
      @(posedge sys_clk) pix_ready <= 1'b0;
      bus(cedc_pkg::PORT_HIDDEN_DAC, 1'b1, 8'h80);
      u_src.edge_byte(8'h34, 1'b1);
      u_src.edge_byte(8'h12, 1'b0);
      step(3);
      chk({pix_valid, pix_out}, {2'h2, 16'h1234});
      pop();
      bus(cedc_pkg::PORT_HIDDEN_DAC, 1'b1, 8'hA0);
      u_src.edge_byte(8'h78, 1'b1);
      u_src.edge_byte(8'h99, 1'b0);
      u_src.edge_byte(8'h56, 1'b1);
      u_src.edge_byte(8'h98, 1'b0);
      step(3);
      chk({pix_valid, pix_out}, {2'h2, 16'h5678});
      pop();
      bus(cedc_pkg::PORT_HIDDEN_DAC, 1'b1, 8'h90);
      u_src.edge_byte(8'h11, 1'b1);
      u_src.edge_byte(8'h80, 1'b0);
      step(3);
      chk({pix_valid, pix_out}, {2'h3, 16'h0011});
      pop();
      bus(cedc_pkg::PORT_HIDDEN_DAC, 1'b1, 8'h00);
      u_src.edge_byte(8'hAB, 1'b1);
      u_src.edge_byte(8'hCD, 1'b0);
      u_src.edge_byte(8'hEF, 1'b1);
      u_src.edge_byte(8'h00, 1'b0);
      u_src.edge_byte(8'h01, 1'b1);
      u_src.edge_byte(8'h00, 1'b0);
      step(3);
      chk({capture_ready, capture_overrun}, 2'h1);
      chk({pix_valid, pix_out}, {2'h2, 16'h00AB});
      pop();
      chk({pix_valid, pix_out}, {2'h2, 16'h00EF});
      pop();
      chk({pix_valid, capture_ready}, 2'h1);
      $display("test pixel capture done");
      bus(cedc_pkg::PORT_HIDDEN_DAC, 1'b1, 8'h8F);
      @(posedge sys_clk) rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      bus(cedc_pkg::PORT_HIDDEN_DAC, 1'b0, 8'h00);
      chk({rv, dac_mode}, {8'h00, cedc_pkg::CEDC_DAC_VGA});
      chk({capture_overrun, display_start_addr}, 20'h0FFFF);
      $display("test reset done");
      end_sim();
   end
endmodule
